// [asd_pkg.sv]
package asd_pkg;
	// Command header, bits 31:16 hold type 3h, pipeline 2h, opcode 1h,
	// sub-operation A 1h and sub-operation B 8h.
	localparam logic [15:0] ASD_HDR_OPCODE = 16'h7128;
	localparam int ASD_HDR_OP_MSB = 31;
	localparam int ASD_HDR_OP_LSB = 16;
	localparam logic [11:0] ASD_HDR_LEN = 12'h004;
	localparam int ASD_HDR_LEN_MSB = 11;
	localparam int ASD_LEN_MSB = 21;
	localparam int ASD_ADDR_MSB = 28;
	// Inline word 3 field positions.
	localparam int ASD_B_METHOD = 31;
	localparam int ASD_B_LOAD = 30;
	localparam int ASD_REW_MSB = 27;
	localparam int ASD_REW_LSB = 24;
	localparam int ASD_REF_MSB = 21;
	localparam int ASD_REF_LSB = 16;
	localparam int ASD_B_EARLY = 14;
	localparam int ASD_B_MV = 12;
	localparam int ASD_B_ENTROPY = 10;
	localparam int ASD_B_MBHDR = 8;
	// Inline word 4 field positions.
	localparam int ASD_OFS_MSB = 31;
	localparam int ASD_OFS_LSB = 16;
	localparam int ASD_B_ALTSKIP = 7;
	localparam int ASD_B_HDRINC = 6;
	localparam int ASD_BIT_MSB = 2;
	// Macroblock index width.
	localparam int ASD_MB_W = 16;
	localparam logic [ASD_MB_W-1:0] ASD_MB_ZERO = 16'h0000;
	localparam logic [7:0] ASD_EPB_BYTE = 8'h03;
	localparam logic [1:0] ASD_ZERO_RUN = 2'h2;
	typedef enum logic [3:0] {
		ASD_IDLE = 4'b0000,
		ASD_LEN = 4'b0001,
		ASD_ADDR = 4'b0010,
		ASD_INL0 = 4'b0011,
		ASD_INL1 = 4'b0100,
		ASD_INL2 = 4'b0101,
		ASD_CHECK = 4'b0110,
		ASD_FILL = 4'b0111,
		ASD_DECODE = 4'b1000
	} asd_state_e;
endpackage

// [asd_epb_scan.sv]
`timescale 1ns/10ps
module asd_epb_scan (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic clk_en,
	input wire logic clear,
	input wire logic enable,
	input wire logic byte_take,
	input wire logic [7:0] byte_data,
	output logic is_epb,
	output logic [asd_pkg::ASD_LEN_MSB:0] epb_count
);
	import asd_pkg::*;
	logic [1:0] zero_run_reg;

	// A 03h after two zero bytes is an emulation prevention byte.
	assign is_epb = enable && (zero_run_reg == ASD_ZERO_RUN) &&
		(byte_data == ASD_EPB_BYTE);

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			zero_run_reg <= 2'h0;
		end else if (clk_en) begin
			if (clear || (byte_take && is_epb)) begin
				zero_run_reg <= 2'h0;
			end else if (byte_take) begin
				if (byte_data != 8'h00) begin
					zero_run_reg <= 2'h0;
				end else if (zero_run_reg != ASD_ZERO_RUN) begin
					zero_run_reg <= zero_run_reg + 2'h1;
				end
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			epb_count <= '0;
		end else if (clk_en) begin
			if (clear) begin
				epb_count <= '0;
			end else if (byte_take && is_epb) begin
				epb_count <= epb_count + 22'h1;
			end
		end
	end
endmodule

// [asd_slice_cmd.sv]
`timescale 1ns/10ps
module asd_slice_cmd (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic clk_en,
	input wire logic cmd_valid,
	input wire logic [31:0] cmd_data,
	output logic cmd_ready,
	output logic cmd_reject,
	input wire logic [31:0] indirect_base,
	output logic fetch_req,
	output logic [31:0] fetch_addr,
	output logic [asd_pkg::ASD_LEN_MSB:0] fetch_len,
	input wire logic bs_valid,
	input wire logic [7:0] bs_data,
	output logic bs_ready,
	output logic dec_byte_valid,
	output logic [7:0] dec_byte_data,
	output logic dec_byte_is_data,
	input wire logic dec_byte_ready,
	output logic [2:0] slice_data_bit_offset,
	output logic [15:0] slice_data_byte_offset,
	output logic [asd_pkg::ASD_LEN_MSB:0] payload_end_index,
	output logic payload_end_valid,
	input wire logic [asd_pkg::ASD_MB_W-1:0] slice_first_macroblock_index,
	input wire logic [7:0] slice_start_column,
	input wire logic [7:0] slice_start_row,
	input wire logic [7:0] pic_width_mbs,
	input wire logic mb_pair_mode,
	input wire logic mb_done,
	input wire logic slice_done,
	output logic [asd_pkg::ASD_MB_W-1:0] running_macroblock_index,
	output logic [7:0] running_column,
	output logic [7:0] running_row,
	output logic slice_index_error,
	output logic conceal_mb_valid,
	output logic [asd_pkg::ASD_MB_W-1:0] conceal_mb_index,
	input wire logic conceal_mb_ready,
	output logic conceal_method,
	output logic [5:0] conceal_reference_select,
	output logic alt_skip_decode_enable,
	output logic slice_header_included,
	input wire logic err_mv,
	input wire logic err_entropy,
	input wire logic err_mb_header,
	input wire logic err_early_end,
	output logic sw_alert,
	output logic auto_handle,
	input wire logic ctx_switch_req,
	output logic ctx_switch_ack,
	output logic busy
);
	import asd_pkg::*;
	localparam int W = ASD_MB_W;

	asd_state_e state_reg, state_next;
	logic [ASD_LEN_MSB:0] len_reg;
	logic [ASD_ADDR_MSB:0] addr_reg;
	logic [31:0] inl3_reg;
	logic [31:0] inl4_reg;
	logic [W-1:0] decoded_reg;
	logic [W-1:0] prev_decoded_reg;
	logic [W-1:0] fill_end_reg;
	logic [ASD_LEN_MSB:0] byte_idx_reg;
	logic take;
	logic hdr_ok;
	logic len_ok;
	logic bs_take;
	logic in_header;
	logic epb_window;
	logic is_epb;
	logic [ASD_LEN_MSB:0] epb_count;
	logic [ASD_LEN_MSB:0] data_start;
	logic [W-1:0] rewind;
	logic [W-1:0] rewind_amt;
	logic [W-1:0] fill_start;
	logic load_sel;
	logic gap;

	assign take = cmd_valid && cmd_ready;
	assign cmd_ready = clk_en && (state_reg <= ASD_INL2);
	assign hdr_ok = cmd_data[ASD_HDR_OP_MSB:ASD_HDR_OP_LSB] ==
		ASD_HDR_OPCODE;
	assign len_ok = cmd_data[ASD_HDR_LEN_MSB:0] == ASD_HDR_LEN;
	assign busy = state_reg != ASD_IDLE;
	// A running command is never interrupted for a switch.
	assign ctx_switch_ack = ctx_switch_req && !busy;

	always_comb begin
		state_next = state_reg;
		unique case (state_reg)
			ASD_IDLE: begin
				if (take && hdr_ok && len_ok) begin
					state_next = ASD_LEN;
				end
			end
			ASD_LEN: begin
				if (take) begin
					state_next = ASD_ADDR;
				end
			end
			ASD_ADDR: begin
				if (take) begin
					state_next = ASD_INL0;
				end
			end
			ASD_INL0: begin
				if (take) begin
					state_next = ASD_INL1;
				end
			end
			ASD_INL1: begin
				if (take) begin
					state_next = ASD_INL2;
				end
			end
			ASD_INL2: begin
				// The sixth word is reserved and discarded.
				if (take) begin
					state_next = ASD_CHECK;
				end
			end
			ASD_CHECK: begin
				state_next = gap ? ASD_FILL : ASD_DECODE;
			end
			ASD_FILL: begin
				if (conceal_mb_ready && conceal_mb_index == fill_end_reg) begin
					state_next = ASD_DECODE;
				end
			end
			ASD_DECODE: begin
				if (slice_done) begin
					state_next = ASD_IDLE;
				end
			end
			default: begin
				state_next = ASD_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			state_reg <= ASD_IDLE;
		end else if (clk_en) begin
			state_reg <= state_next;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			cmd_reject <= 1'b0;
		end else if (clk_en) begin
			cmd_reject <= take && (state_reg == ASD_IDLE) &&
				!(hdr_ok && len_ok);
		end
	end

	// Inline state stays put until the next accepted command overwrites it.
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			len_reg <= '0;
			addr_reg <= '0;
			inl3_reg <= 32'h0;
			inl4_reg <= 32'h0;
		end else if (clk_en && take) begin
			unique case (state_reg)
				ASD_LEN: len_reg <= cmd_data[ASD_LEN_MSB:0];
				ASD_ADDR: addr_reg <= cmd_data[ASD_ADDR_MSB:0];
				ASD_INL0: inl3_reg <= cmd_data;
				ASD_INL1: inl4_reg <= cmd_data;
				default: begin
				end
			endcase
		end
	end

	assign conceal_method = inl3_reg[ASD_B_METHOD];
	assign conceal_reference_select =
		inl3_reg[ASD_REF_MSB:ASD_REF_LSB];
	assign alt_skip_decode_enable = inl4_reg[ASD_B_ALTSKIP];
	assign slice_header_included = inl4_reg[ASD_B_HDRINC];
	assign slice_data_bit_offset = inl4_reg[ASD_BIT_MSB:0];
	// Without the header in the stream the offset is forced to zero, so a
	// stale value from the issuer cannot shift the data.
	assign slice_data_byte_offset = slice_header_included ?
		inl4_reg[ASD_OFS_MSB:ASD_OFS_LSB] : 16'h0000;
	assign load_sel = inl3_reg[ASD_B_LOAD];

	// Rewind is scaled for pair mode and capped by the previous slice.
	assign rewind = {12'h000, inl3_reg[ASD_REW_MSB:ASD_REW_LSB]};
	always_comb begin
		rewind_amt = mb_pair_mode ? {rewind[W-2:0], 1'b0} : rewind;
		if (prev_decoded_reg < rewind_amt) begin
			rewind_amt = prev_decoded_reg;
		end
		if (rewind_amt > running_macroblock_index) begin
			rewind_amt = running_macroblock_index;
		end
	end
	assign fill_start = running_macroblock_index - rewind_amt;
	assign gap = !load_sel &&
		(slice_first_macroblock_index > running_macroblock_index);

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			running_macroblock_index <= ASD_MB_ZERO;
			running_column <= 8'h00;
			running_row <= 8'h00;
		end else if (clk_en) begin
			if (state_reg == ASD_CHECK && load_sel) begin
				running_macroblock_index <= slice_first_macroblock_index;
				running_column <= slice_start_column;
				running_row <= slice_start_row;
			end else if (state_reg == ASD_CHECK &&
				slice_first_macroblock_index < running_macroblock_index) begin
				running_macroblock_index <=
					slice_first_macroblock_index;
			end else if (state_reg == ASD_FILL && state_next == ASD_DECODE) begin
				running_macroblock_index <= slice_first_macroblock_index;
			end else if (state_reg == ASD_DECODE && mb_done) begin
				running_macroblock_index <= running_macroblock_index + 16'h1;
				if (running_column + 8'h01 >= pic_width_mbs) begin
					running_column <= 8'h00;
					running_row <= running_row + 8'h01;
				end else begin
					running_column <= running_column + 8'h01;
				end
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			slice_index_error <= 1'b0;
		end else if (clk_en && state_reg == ASD_CHECK) begin
			slice_index_error <= !load_sel &&
				(slice_first_macroblock_index !=
				running_macroblock_index);
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			decoded_reg <= ASD_MB_ZERO;
			prev_decoded_reg <= ASD_MB_ZERO;
		end else if (clk_en) begin
			if (state_reg == ASD_DECODE && slice_done) begin
				prev_decoded_reg <= decoded_reg + {15'h0000, mb_done};
				decoded_reg <= ASD_MB_ZERO;
			end else if (state_reg == ASD_DECODE && mb_done) begin
				decoded_reg <= decoded_reg + 16'h1;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			conceal_mb_valid <= 1'b0;
			conceal_mb_index <= ASD_MB_ZERO;
			fill_end_reg <= ASD_MB_ZERO;
		end else if (clk_en) begin
			if (state_reg == ASD_CHECK && gap) begin
				conceal_mb_valid <= 1'b1;
				conceal_mb_index <= fill_start;
				fill_end_reg <= slice_first_macroblock_index - 16'h1;
			end else if (state_reg == ASD_FILL && conceal_mb_ready) begin
				conceal_mb_index <= conceal_mb_index + 16'h1;
				conceal_mb_valid <= conceal_mb_index != fill_end_reg;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			fetch_req <= 1'b0;
			fetch_addr <= 32'h0;
			fetch_len <= '0;
		end else if (clk_en) begin
			fetch_req <= 1'b0;
			if (state_reg != ASD_DECODE && state_next == ASD_DECODE &&
				len_reg != '0) begin
				fetch_req <= 1'b1;
				fetch_addr <= indirect_base + {3'h0, addr_reg};
				fetch_len <= len_reg;
			end
		end
	end

	// Bytes pass straight to the decoder; nothing is buffered here.
	assign bs_ready = clk_en && state_reg == ASD_DECODE &&
		byte_idx_reg < len_reg && dec_byte_ready;
	assign bs_take = bs_valid && bs_ready;
	assign dec_byte_valid = bs_valid && bs_ready;
	assign dec_byte_data = bs_data;
	assign in_header = slice_header_included && byte_idx_reg < data_start;
	assign epb_window = slice_header_included && byte_idx_reg <= data_start;
	assign data_start = {6'h00, slice_data_byte_offset} + epb_count;
	assign dec_byte_is_data = !(in_header || is_epb);

	asd_epb_scan u_epb (
		.clk(clk),
		.rst_n(rst_n),
		.clk_en(clk_en),
		.clear(fetch_req),
		.enable(epb_window),
		.byte_take(bs_take),
		.byte_data(bs_data),
		.is_epb(is_epb),
		.epb_count(epb_count)
	);

	// Trailing zero padding never moves the end marker.
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			byte_idx_reg <= '0;
			payload_end_index <= '0;
			payload_end_valid <= 1'b0;
		end else if (clk_en) begin
			if (fetch_req) begin
				byte_idx_reg <= '0;
				payload_end_index <= '0;
				payload_end_valid <= 1'b0;
			end else if (bs_take) begin
				byte_idx_reg <= byte_idx_reg + 22'h1;
				if (bs_data != 8'h00) begin
					payload_end_index <= byte_idx_reg;
				end
				payload_end_valid <= byte_idx_reg + 22'h1 == len_reg;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			sw_alert <= 1'b0;
			auto_handle <= 1'b0;
		end else if (clk_en) begin
			sw_alert <= busy && (
				(err_early_end && inl3_reg[ASD_B_EARLY]) ||
				(err_mv && inl3_reg[ASD_B_MV]) ||
				(err_entropy && inl3_reg[ASD_B_ENTROPY]) ||
				(err_mb_header && inl3_reg[ASD_B_MBHDR]));
			auto_handle <= busy && (
				(err_early_end && !inl3_reg[ASD_B_EARLY]) ||
				(err_mv && !inl3_reg[ASD_B_MV]) ||
				(err_entropy && !inl3_reg[ASD_B_ENTROPY]) ||
				(err_mb_header && !inl3_reg[ASD_B_MBHDR]));
		end
	end

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_n || !clk_en);

	sequence s_bad_header;
		take && state_reg == ASD_IDLE && !hdr_ok;
	endsequence
	sequence s_gap_check;
		state_reg == ASD_CHECK && gap;
	endsequence

	AST_BAD_HEADER: assert property (
		s_bad_header |=> cmd_reject && state_reg == ASD_IDLE)
		else $error("bad header not rejected");
	AST_BAD_LENGTH: assert property (
		take && state_reg == ASD_IDLE && hdr_ok && !len_ok |=>
		cmd_reject && !busy)
		else $error("bad length not rejected");
	AST_NO_ZERO_FETCH: assert property (
		fetch_req |-> fetch_len != '0 && state_reg == ASD_DECODE)
		else $error("fetch with zero length");
	AST_FETCH_ADDR: assert property (
		fetch_req |-> fetch_addr == indirect_base + {3'h0, addr_reg})
		else $error("fetch address wrong");
	AST_STATE_HELD: assert property (
		!(take && state_reg == ASD_INL0) |=> $stable(inl3_reg))
		else $error("inline state changed without command");
	AST_INDEX_LOWER: assert property (
		state_reg == ASD_CHECK && !load_sel &&
		slice_first_macroblock_index < running_macroblock_index |=>
		running_macroblock_index == $past(slice_first_macroblock_index) &&
		slice_index_error)
		else $error("running index not lowered");
	AST_FILL_START: assert property (
		s_gap_check |=>
		conceal_mb_valid && conceal_mb_index == $past(fill_start) &&
		state_reg == ASD_FILL ##1 slice_index_error)
		else $error("fill did not start at rewound index");
	AST_LOAD_INDEX: assert property (
		state_reg == ASD_CHECK && load_sel |=>
		running_column == $past(slice_start_column) &&
		!slice_index_error && state_reg == ASD_DECODE)
		else $error("index not loaded from slice");
	AST_ALERT: assert property (
		busy && err_mv && inl3_reg[ASD_B_MV] |=> sw_alert && !auto_handle ||
		$past(err_early_end || err_entropy || err_mb_header))
		else $error("policy alert missing");
	AST_NO_SWITCH: assert property (
		busy |-> !ctx_switch_ack)
		else $error("context switch during command");
endmodule

// [asd_stream_model.sv]
`timescale 1ns/10ps
module asd_stream_model (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic slow,
	input wire logic cmd_ready,
	output logic cmd_valid,
	output logic [31:0] cmd_data,
	input wire logic fetch_req,
	input wire logic [asd_pkg::ASD_LEN_MSB:0] fetch_len,
	input wire logic bs_ready,
	output logic bs_valid,
	output logic [7:0] bs_data
);
	import asd_pkg::*;
	// Leading 00 00 03 is an emulation prevention run; the tail is padding.
	logic [7:0] mem [8];
	logic [21:0] idx_reg;
	logic [21:0] left_reg;
	logic [7:0] last_reg;
	int n_stall = 0;
	initial begin
		mem = '{8'h00, 8'h00, 8'h03, 8'h05, 8'h00, 8'h07, 8'h00, 8'h00};
		cmd_valid = 1'h0;
		cmd_data = 32'h0;
	end
	// An idle byte lane shows the inverse of the last byte, never a copy.
	assign bs_data = bs_valid ? mem[idx_reg[2:0]] : ~last_reg;
	always @(posedge clk) begin
		if (!rst_n || fetch_req) begin
			idx_reg <= 22'h0;
			left_reg <= fetch_req ? fetch_len : 22'h0;
			bs_valid <= 1'h0;
			last_reg <= 8'h00;
		end else if (!bs_valid || bs_ready) begin
			if (bs_valid) begin
				idx_reg <= idx_reg + 22'h1;
				last_reg <= bs_data;
			end
			left_reg <= left_reg - {21'h0, bs_valid};
			bs_valid <= left_reg != {21'h0, bs_valid} && !(slow && bs_valid);
		end
	end
	task automatic send_word(input logic [31:0] w);
		int n;
		n = 0;
		cmd_valid <= 1'h1;
		cmd_data <= w;
		do begin
			@(posedge clk);
			n++;
		end while (!cmd_ready && n < 50);
		if (!cmd_ready)
			n_stall++;
	endtask
	task automatic stop();
		cmd_valid <= 1'h0;
	endtask
	task automatic send_cmd(input logic [21:0] len, input logic [28:0] addr,
		input logic [31:0] i3, input logic [31:0] i4);
		send_word({ASD_HDR_OPCODE, 4'h0, ASD_HDR_LEN});
		send_word({10'h000, len});
		send_word({3'h0, len == 22'h0 ? 29'h0 : addr});
		send_word(i3);
		send_word(i4);
		send_word(32'h0);
		stop();
	endtask
endmodule

// [tb_top.sv]
`timescale 1ns/10ps
module tb_top;
	import asd_pkg::*;
	typedef struct packed {
		logic [15:0] first;
		logic [31:0] i3;
		logic [31:0] i4;
		logic [21:0] len;
		logic [28:0] addr;
		logic [7:0] ndec;
		logic pair;
		logic slow;
		logic err;
		logic [7:0] fill;
		logic [15:0] fidx;
		logic [21:0] pend;
		logic [7:0] hdr;
	} asd_row_s;
	logic clk = 1'h0;
	logic rst_n = 1'h0;
	logic [31:0] base = 32'h0;
	logic [15:0] first_idx = 16'h0;
	logic pair = 1'h0;
	logic slow = 1'h0;
	logic mb_done = 1'h0;
	logic slice_done = 1'h0;
	logic c_ready = 1'h0;
	logic [3:0] errs = 4'h0;
	logic ctx_req = 1'h0;
	logic cmd_valid, cmd_ready, cmd_reject, fetch_req, bs_valid, bs_ready;
	logic [31:0] cmd_data, fetch_addr;
	logic [21:0] fetch_len, pend;
	logic [7:0] bs_data;
	logic dec_valid, dec_is_data, pend_valid, busy, ctx_ack;
	logic [15:0] run_idx, c_idx, byte_ofs, fill_first;
	logic c_valid, err_flag, sw_alert, auto_handle, c_method, alt_skip, hdr_inc;
	logic [5:0] c_ref;
	logic [2:0] bit_ofs;
	logic [3:0] pol;
	logic en = 1'h1;
	logic [7:0] col, row_pos, run_col, run_row, dec_data, dat0, exp_b;
	int n_dat = 0;
	int b_dat;
	int n_mismatch = 0;
	int check_count = 0;
	int n_fetch = 0;
	int n_fill = 0;
	int n_hdr = 0;
	int b_fill, b_fetch, b_hdr;
	asd_row_s rows [5];
	asd_row_s r;

	always #20 clk = ~clk;
	// Start position follows the index for a picture 16 macroblocks wide.
	assign col = {4'h0, first_idx[3:0]};
	assign row_pos = first_idx[11:4];

	asd_slice_cmd u_asd_slice_cmd (.clk(clk), .rst_n(rst_n), .clk_en(en),
		.cmd_valid(cmd_valid), .cmd_data(cmd_data), .cmd_ready(cmd_ready),
		.cmd_reject(cmd_reject), .indirect_base(base), .fetch_req(fetch_req),
		.fetch_addr(fetch_addr), .fetch_len(fetch_len), .bs_valid(bs_valid),
		.bs_data(bs_data), .bs_ready(bs_ready), .dec_byte_valid(dec_valid),
		.dec_byte_data(dec_data), .dec_byte_is_data(dec_is_data),
		.dec_byte_ready(1'h1), .slice_data_bit_offset(bit_ofs),
		.slice_data_byte_offset(byte_ofs), .payload_end_index(pend),
		.payload_end_valid(pend_valid),
		.slice_first_macroblock_index(first_idx), .slice_start_column(col),
		.slice_start_row(row_pos), .pic_width_mbs(8'h10), .mb_pair_mode(pair),
		.mb_done(mb_done), .slice_done(slice_done),
		.running_macroblock_index(run_idx), .running_column(run_col),
		.running_row(run_row), .slice_index_error(err_flag),
		.conceal_mb_valid(c_valid), .conceal_mb_index(c_idx),
		.conceal_mb_ready(c_ready), .conceal_method(c_method),
		.conceal_reference_select(c_ref), .alt_skip_decode_enable(alt_skip),
		.slice_header_included(hdr_inc), .err_mv(errs[2]),
		.err_entropy(errs[1]), .err_mb_header(errs[0]),
		.err_early_end(errs[3]), .sw_alert(sw_alert),
		.auto_handle(auto_handle), .ctx_switch_req(ctx_req),
		.ctx_switch_ack(ctx_ack), .busy(busy));

	asd_stream_model u_asd_stream_model (.clk(clk), .rst_n(rst_n),
		.slow(slow), .cmd_ready(cmd_ready), .cmd_valid(cmd_valid),
		.cmd_data(cmd_data), .fetch_req(fetch_req), .fetch_len(fetch_len),
		.bs_ready(bs_ready), .bs_valid(bs_valid), .bs_data(bs_data));

	// Concealment handshake stalls every other cycle on purpose.
	always @(posedge clk) begin
		c_ready <= ~c_ready;
		if (fetch_req)
			n_fetch <= n_fetch + 1;
		if (c_valid && c_ready && n_fill == b_fill)
			fill_first <= c_idx;
		if (c_valid && c_ready)
			n_fill <= n_fill + 1;
		if (dec_valid && !dec_is_data)
			n_hdr <= n_hdr + 1;
		if (dec_valid && dec_is_data && n_dat == b_dat)
			dat0 <= dec_data;
		if (dec_valid && dec_is_data)
			n_dat <= n_dat + 1;
	end

	task automatic summarize();
		if (n_mismatch == 0 && check_count > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] seen,
		input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("BAD %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic step(inout int n);
		@(posedge clk);
		n++;
		if (n > 1000) begin
			n_mismatch++;
			summarize();
		end
	endtask
	task automatic enter_decode(input logic [7:0] fill, input logic [21:0] len);
		int w;
		w = 0;
		while (n_fill - b_fill < fill) step(w);
		repeat (3) @(posedge clk);
		while (len != 22'h0 && !pend_valid) step(w);
		#1;
	endtask
	task automatic close_slice(input logic [7:0] ndec);
		int w;
		w = 0;
		@(posedge clk);
		mb_done <= 1'h1;
		repeat (ndec) @(posedge clk);
		mb_done <= 1'h0;
		slice_done <= 1'h1;
		@(posedge clk);
		slice_done <= 1'h0;
		while (busy) step(w);
		#1;
	endtask

	initial begin
		// The byte offset stays zero whenever the header is not supplied.
		rows[0] = '{16'h0, 32'h0, 32'h0, 22'h8, 29'h40, 8'h3, 1'h0, 1'h0,
			1'h0, 8'h0, 16'h0, 22'h5, 8'h0};
		rows[1] = '{16'h7, 32'h8225_0000, 32'h0002_00c5, 22'h8, 29'h1fff_fff0,
			8'h2, 1'h1, 1'h1, 1'h1, 8'h7, 16'h0, 22'h5, 8'h3};
		rows[2] = '{16'h4, 32'h0f00_0000, 32'h0, 22'h0, 29'h0, 8'h5, 1'h0,
			1'h0, 1'h1, 8'h0, 16'h0, 22'h0, 8'h0};
		rows[3] = '{16'h14, 32'h0100_0000, 32'h3, 22'h4, 29'h10, 8'h1, 1'h0,
			1'h0, 1'h1, 8'hc, 16'h8, 22'h3, 8'h0};
		rows[4] = '{16'h1e, 32'h4000_0000, 32'h80, 22'h8, 29'h0, 8'h2, 1'h0,
			1'h0, 1'h0, 8'h0, 16'h0, 22'h5, 8'h0};
		repeat (8) @(posedge clk);
		rst_n <= 1'h1;
		@(posedge clk);
		#1;
		chk("cmd_ready", cmd_ready, 1'h1);
		chk("busy", busy, 1'h0);
		chk("running", run_idx, 16'h0);
		chk("index_error", err_flag, 1'h0);
		u_asd_stream_model.send_word(32'h7129_0004);
		#1;
		chk("reject_op", cmd_reject, 1'h1);
		u_asd_stream_model.send_word(32'h7128_0005);
		#1;
		chk("reject_len", cmd_reject, 1'h1);
		chk("busy_rej", busy, 1'h0);
		u_asd_stream_model.stop();
		for (int i = 0; i < 5; i++) begin
			r = rows[i];
			@(posedge clk);
			base <= 32'h0100_0000 * i;
			first_idx <= r.first;
			pair <= r.pair;
			slow <= r.slow;
			b_fill = n_fill;
			b_fetch = n_fetch;
			b_hdr = n_hdr;
			b_dat = n_dat;
			@(posedge clk);
			u_asd_stream_model.send_cmd(r.len, r.addr, r.i3, r.i4);
			enter_decode(r.fill, r.len);
			chk("index_error", err_flag, r.err);
			chk("fill_count", n_fill - b_fill, r.fill);
			if (r.fill != 8'h0)
				chk("fill_start", fill_first, r.fidx);
			chk("fetches", n_fetch - b_fetch, r.len != 22'h0);
			if (r.len != 22'h0) begin
				chk("addr", fetch_addr, base + {3'h0, r.addr});
				chk("fetch_len", fetch_len, r.len);
				chk("payload_end", pend, r.pend);
				chk("hdr_bytes", n_hdr - b_hdr, r.hdr);
				exp_b = u_asd_stream_model.mem[r.hdr[2:0]];
				chk("data0", dat0, exp_b);
			end
			close_slice(r.ndec);
			chk("running", run_idx, r.first + r.ndec);
			if (r.i3[30]) begin
				chk("column", run_col, (r.first + r.ndec) % 16);
				chk("row", run_row, (r.first + r.ndec) / 16);
			end
			chk("method", c_method, r.i3[31]);
			chk("ref", c_ref, r.i3[21:16]);
			chk("alt_skip", alt_skip, r.i4[7]);
			chk("hdr_inc", hdr_inc, r.i4[6]);
			chk("bit_ofs", bit_ofs, r.i4[2:0]);
			chk("byte_ofs", byte_ofs, r.i4[31:16]);
		end
		@(posedge clk);
		ctx_req <= 1'h1;
		first_idx <= 16'h20;
		b_fill = n_fill;
		u_asd_stream_model.send_cmd(22'h0, 29'h0, 32'h0000_5100, 32'h0);
		enter_decode(8'h0, 22'h0);
		chk("ctx_ack_busy", ctx_ack, 1'h0);
		// Error lines: mb header, entropy, vector range, early end.
		pol = 4'b1101;
		for (int k = 0; k < 4; k++) begin
			errs <= 4'h1 << k;
			@(posedge clk);
			errs <= 4'h0;
			#1;
			chk("sw_alert", sw_alert, pol[k]);
			chk("auto_handle", auto_handle, !pol[k]);
		end
		// A low enable must freeze the count even with a decoded pulse.
		@(posedge clk);
		en <= 1'h0;
		mb_done <= 1'h1;
		repeat (2) @(posedge clk);
		en <= 1'h1;
		mb_done <= 1'h0;
		#1;
		chk("frozen", run_idx, 16'h20);
		close_slice(8'h1);
		chk("ctx_ack_idle", ctx_ack, 1'h1);
		chk("running_end", run_idx, 16'h21);
		// A reset between commands must drop the held index and end marker.
		@(posedge clk);
		rst_n <= 1'h0;
		repeat (2) @(posedge clk);
		rst_n <= 1'h1;
		@(posedge clk);
		#1;
		chk("rst_running", run_idx, 16'h0);
		chk("rst_ready", cmd_ready, 1'h1);
		chk("rst_end_valid", pend_valid, 1'h0);
		chk("stalls", u_asd_stream_model.n_stall, 0);
		summarize();
	end
endmodule
